// [shared/fsq_pkg.sv]
package fsq_pkg;

  localparam int ADDR_W = 20;
  localparam int WORD_W = 16;
  localparam int CNT_W  = 4;

  // Word after a jump that triggers the extra increment: 0X40h or 0X50h
  localparam logic [WORD_W-1:0] JUMP_QUIRK_MASK = 16'hF0FF;
  localparam logic [WORD_W-1:0] JUMP_QUIRK_PAT0 = 16'h0040;
  localparam logic [WORD_W-1:0] JUMP_QUIRK_PAT1 = 16'h0050;
  localparam logic [ADDR_W-1:0] JUMP_EXTRA_INC  = 20'h00002;

  // Stack pointer step of one restore, by operand width
  localparam logic [ADDR_W-1:0] STEP_ADDR_WIDTH = 20'h00004;
  localparam logic [ADDR_W-1:0] STEP_WORD_WIDTH = 20'h00002;

  // Bytes at the end of an isolated section hit by fetch anomaly
  localparam logic [ADDR_W-1:0] TAIL_DEBUG_BYTES = 20'h00008;
  localparam logic [ADDR_W-1:0] TAIL_FREE_BYTES  = 20'h00004;

  // Memory map: section 0 holds the stack and ends one below STACK_TOP
  localparam int NUM_SEC = 3;
  localparam logic [ADDR_W-1:0] SEC_BASE  [NUM_SEC] = '{20'h01C00, 20'h04400, 20'h10000};
  localparam logic [ADDR_W-1:0] SEC_LIMIT [NUM_SEC] = '{20'h023FF, 20'h0FFFF, 20'h13FFF};
  localparam logic [ADDR_W-1:0] STACK_TOP = 20'h02400;

  typedef enum logic [1:0] {RS_IDLE, RS_POP, RS_EXTRA} fsq_restore_type;

  // True when another section starts right after section idx
  function automatic logic has_section_above(input int idx);
    logic found;
    found = 1'b0;
    for (int j = 0; j < NUM_SEC; j++) begin
      if (SEC_BASE[j] == SEC_LIMIT[idx] + 20'h00001) begin
        found = 1'b1;
      end
    end
    return found;
  endfunction

  // Word pattern that corrupts the program counter after a jump
  function automatic logic is_jump_quirk(input logic [WORD_W-1:0] word);
    return ((word & JUMP_QUIRK_MASK) == JUMP_QUIRK_PAT0) ||
           ((word & JUMP_QUIRK_MASK) == JUMP_QUIRK_PAT1);
  endfunction

endpackage

// [verilog/fsq_map_check.sv]
`timescale 1ns/1ps
module fsq_map_check (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic [fsq_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                       i_debug,
  output logic                            o_mapped,
  output logic                            o_in_tail
);
  import fsq_pkg::*;

  logic [ADDR_W-1:0] tail_len;

  // Breakpoint debugging widens the affected tail from four to eight bytes
  assign tail_len = i_debug ? TAIL_DEBUG_BYTES : TAIL_FREE_BYTES;

  // Section lookup; only sections with nothing directly above have a tail
  always_comb begin
    o_mapped  = 1'b0;
    o_in_tail = 1'b0;
    for (int i = 0; i < NUM_SEC; i++) begin
      if (i_addr >= SEC_BASE[i] && i_addr <= SEC_LIMIT[i]) begin
        o_mapped = 1'b1;
        if (!has_section_above(i) && (SEC_LIMIT[i] - i_addr) < tail_len) begin
          o_in_tail = 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_tail_free_size;
    !i_debug && o_in_tail |-> (i_addr == SEC_LIMIT[0] - 20'h00003) || (i_addr >= SEC_LIMIT[0] - 20'h00003 &&
      i_addr <= SEC_LIMIT[0]) || (i_addr >= SEC_LIMIT[2] - 20'h00003 && i_addr <= SEC_LIMIT[2]);
  endproperty
  a_tail_free_size: assert property (p_tail_free_size) else $error("tail wider than four bytes in free run");

  property p_tail_only_mapped;
    o_in_tail |-> o_mapped;
  endproperty
  a_tail_only_mapped: assert property (p_tail_only_mapped) else $error("tail hit outside any section");

endmodule

// [verilog/fsq_core_quirks.sv]
`timescale 1ns/1ps
module fsq_core_quirks (
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_RESET_N,
  input  wire logic                        I_JUMP_TAKEN,
  input  wire logic [fsq_pkg::ADDR_W-1:0]  I_JUMP_TARGET,
  input  wire logic [fsq_pkg::WORD_W-1:0]  I_NEXT_WORD,
  input  wire logic                        I_RESTORE_START,
  input  wire logic [fsq_pkg::CNT_W-1:0]   I_RESTORE_COUNT,
  input  wire logic                        I_RESTORE_ADDR_WIDTH,
  input  wire logic [fsq_pkg::ADDR_W-1:0]  I_SP_INIT,
  input  wire logic                        I_FETCH_VALID,
  input  wire logic [fsq_pkg::ADDR_W-1:0]  I_FETCH_ADDR,
  input  wire logic                        I_FETCH_PC_MODIFY,
  input  wire logic                        I_DEBUG_MODE,
  input  wire logic                        I_DATA_ACCESS,
  input  wire logic [fsq_pkg::ADDR_W-1:0]  I_DATA_ADDR,
  input  wire logic                        I_VACANT_ACCESS_IRQ_ENABLE,
  input  wire logic                        I_VACANT_ACCESS_FLAG_CLEAR,
  output logic      [fsq_pkg::ADDR_W-1:0]  O_PC,
  output logic                             O_PC_VALID,
  output logic                             O_STACK_READ,
  output logic      [fsq_pkg::ADDR_W-1:0]  O_STACK_READ_ADDR,
  output logic                             O_STACK_READ_EXTRA,
  output logic      [fsq_pkg::ADDR_W-1:0]  O_SP,
  output logic                             O_RESTORE_BUSY,
  output logic                             O_VACANT_ACCESS_FLAG,
  output logic                             O_VACANT_IRQ
);
  import fsq_pkg::*;

  logic [1:0]        rst_sync;
  logic              rst_n;
  fsq_restore_type   restore_state;
  logic [CNT_W-1:0]  remaining;
  logic              addr_width;
  logic [ADDR_W-1:0] step;
  logic              extra_mapped;
  logic              fetch_mapped;
  logic              fetch_in_tail;
  logic              data_mapped;
  logic              vacant_event;

  // Reset released through two flops so no flop leaves reset mid-edge
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Jump resolution, including the stray increment of two
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_PC       <= 20'h00000;
      O_PC_VALID <= 1'b0;
    end else begin
      O_PC_VALID <= I_JUMP_TAKEN;
      if (I_JUMP_TAKEN) begin
        if (is_jump_quirk(I_NEXT_WORD)) begin
          O_PC <= I_JUMP_TARGET + JUMP_EXTRA_INC;
        end else begin
          O_PC <= I_JUMP_TARGET;
        end
      end
    end
  end

  assign step = addr_width ? STEP_ADDR_WIDTH : STEP_WORD_WIDTH;

  // Restore sequencer; a zero count is ignored, starts while busy are dropped
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      restore_state      <= RS_IDLE;
      remaining          <= 4'h0;
      addr_width         <= 1'b0;
      O_SP               <= 20'h00000;
      O_STACK_READ       <= 1'b0;
      O_STACK_READ_ADDR  <= 20'h00000;
      O_STACK_READ_EXTRA <= 1'b0;
    end else begin
      O_STACK_READ       <= 1'b0;
      O_STACK_READ_EXTRA <= 1'b0;
      case (restore_state)
        RS_IDLE: begin
          if (I_RESTORE_START && I_RESTORE_COUNT != 4'h0) begin
            O_SP          <= I_SP_INIT;
            remaining     <= I_RESTORE_COUNT;
            addr_width    <= I_RESTORE_ADDR_WIDTH;
            restore_state <= RS_POP;
          end
        end
        RS_POP: begin
          O_STACK_READ      <= 1'b1;
          O_STACK_READ_ADDR <= O_SP;
          O_SP              <= O_SP + step;
          remaining         <= remaining - 4'h1;
          if (remaining == 4'h1) begin
            restore_state <= RS_EXTRA;
          end
        end
        RS_EXTRA: begin
          // Unwanted read at the already incremented pointer
          O_STACK_READ       <= 1'b1;
          O_STACK_READ_ADDR  <= O_SP;
          O_STACK_READ_EXTRA <= 1'b1;
          restore_state      <= RS_IDLE;
        end
        default: begin
          restore_state <= RS_IDLE;
        end
      endcase
    end
  end

  assign O_RESTORE_BUSY = (restore_state != RS_IDLE);

  // Stack read address only leaves the map once it reaches the stack top
  fsq_map_check u_stack_map (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (rst_n),
    .i_addr    (O_STACK_READ_ADDR),
    .i_debug   (I_DEBUG_MODE),
    .o_mapped  (extra_mapped),
    .o_in_tail ()
  );

  fsq_map_check u_fetch_map (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (rst_n),
    .i_addr    (I_FETCH_ADDR),
    .i_debug   (I_DEBUG_MODE),
    .o_mapped  (fetch_mapped),
    .o_in_tail (fetch_in_tail)
  );

  fsq_map_check u_data_map (
    .i_clk     (I_CLK_SYS),
    .i_rst_n   (rst_n),
    .i_addr    (I_DATA_ADDR),
    .i_debug   (I_DEBUG_MODE),
    .o_mapped  (data_mapped),
    .o_in_tail ()
  );

  // All vacant-access sources; the stack and fetch ones are the anomalies
  assign vacant_event = (O_STACK_READ && !extra_mapped) ||
                        (I_FETCH_VALID && (!fetch_mapped || (I_FETCH_PC_MODIFY && fetch_in_tail))) ||
                        (I_DATA_ACCESS && !data_mapped);

  // Sticky flag; a new event beats a clear in the same cycle
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_VACANT_ACCESS_FLAG <= 1'b0;
    end else if (vacant_event) begin
      O_VACANT_ACCESS_FLAG <= 1'b1;
    end else if (I_VACANT_ACCESS_FLAG_CLEAR) begin
      O_VACANT_ACCESS_FLAG <= 1'b0;
    end
  end

  // Level request, held while flag and enable are both set
  assign O_VACANT_IRQ = O_VACANT_ACCESS_FLAG && I_VACANT_ACCESS_IRQ_ENABLE;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence s_last_pop;
    restore_state == RS_POP && remaining == 4'h1;
  endsequence

  sequence s_extra_read;
    O_STACK_READ && O_STACK_READ_EXTRA;
  endsequence

  property p_jump_quirk;
    I_JUMP_TAKEN && is_jump_quirk(I_NEXT_WORD) |=> O_PC_VALID && O_PC == $past(I_JUMP_TARGET) + JUMP_EXTRA_INC;
  endproperty
  a_jump_quirk: assert property (p_jump_quirk) else $error("pc not advanced by two after jump");

  property p_jump_plain;
    I_JUMP_TAKEN && !is_jump_quirk(I_NEXT_WORD) |=> O_PC == $past(I_JUMP_TARGET);
  endproperty
  a_jump_plain: assert property (p_jump_plain) else $error("plain jump landed off target");

  property p_extra_follows_last;
    s_last_pop |=> (O_STACK_READ && !O_STACK_READ_EXTRA) ##1 s_extra_read ##1 !O_STACK_READ;
  endproperty
  a_extra_follows_last: assert property (p_extra_follows_last) else $error("extra restore read missing");

  property p_extra_addr;
    s_extra_read |-> O_STACK_READ_ADDR == $past(O_STACK_READ_ADDR) + step && O_SP == O_STACK_READ_ADDR;
  endproperty
  a_extra_addr: assert property (p_extra_addr) else $error("extra read not after last increment");

  property p_extra_vacant;
    (s_extra_read and !extra_mapped) |=> O_VACANT_ACCESS_FLAG;
  endproperty
  a_extra_vacant: assert property (p_extra_vacant) else $error("vacant extra read did not set flag");

  property p_below_top_mapped;
    (s_extra_read and (O_STACK_READ_ADDR < STACK_TOP && O_STACK_READ_ADDR >= SEC_BASE[0])) |-> extra_mapped;
  endproperty
  a_below_top_mapped: assert property (p_below_top_mapped) else $error("read below stack top seen vacant");

  property p_fetch_tail;
    I_FETCH_VALID && I_FETCH_PC_MODIFY && fetch_in_tail |=> O_VACANT_ACCESS_FLAG;
  endproperty
  a_fetch_tail: assert property (p_fetch_tail) else $error("tail fetch did not set flag");

  property p_flag_sticky;
    O_VACANT_ACCESS_FLAG && !I_VACANT_ACCESS_FLAG_CLEAR |=> O_VACANT_ACCESS_FLAG;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  property p_irq_masked;
    !I_VACANT_ACCESS_IRQ_ENABLE || !O_VACANT_ACCESS_FLAG |-> !O_VACANT_IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked");

endmodule

// [testbench/fsq_mem_model.sv]
`timescale 1ns/1ps
// Stack memory as seen from the far side: counts the reads the core makes
module fsq_mem_model (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_count_clear,
  input  wire logic                       i_stack_read,
  input  wire logic [fsq_pkg::ADDR_W-1:0] i_stack_read_addr,
  output logic      [7:0]                 o_read_count,
  output logic      [7:0]                 o_over_count
);
  import fsq_pkg::*;

  // Every strobe counts, the spurious one included, so an extra read is visible
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_count <= 8'h00;
    end else if (i_count_clear) begin
      o_read_count <= 8'h00;
    end else if (i_stack_read) begin
      o_read_count <= o_read_count + 8'h01;
    end
  end

  // Reads past the stack top are the ones that can land on vacant memory
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_over_count <= 8'h00;
    end else if (i_count_clear) begin
      o_over_count <= 8'h00;
    end else if (i_stack_read && i_stack_read_addr >= STACK_TOP) begin
      o_over_count <= o_over_count + 8'h01;
    end
  end
endmodule

// [testbench/fsq_core_quirks_tb_top.sv]
`timescale 1ns/1ps
module fsq_core_quirks_tb_top;
  import fsq_pkg::*;
  localparam int LIMIT = 6000;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic extra;} fsq_read_type;
  logic clk, rst_n, jt, rs, aw, fv, pm, dbg, da, en, clr, cc;
  logic [ADDR_W-1:0] tgt, spi, fa, dadr, o_pc, o_rd_addr, o_sp;
  logic [WORD_W-1:0] nw;
  logic [CNT_W-1:0]  cnt;
  logic o_pc_valid, o_rd, o_rd_extra, o_busy, o_flag, o_irq;
  logic [7:0] rd_count, over_count;
  logic [WORD_W-1:0] words [8] = '{16'h0040, 16'h0050, 16'h0140, 16'hF050, 16'h0041, 16'h0060, 16'h1000, 16'h0000};
  int num_errors, checked, cycles;
  logic [ADDR_W-1:0] exp_pc [$];
  fsq_read_type      exp_rd [$];

  fsq_core_quirks i_fsq_core_quirks (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_JUMP_TAKEN(jt),
    .I_JUMP_TARGET(tgt), .I_NEXT_WORD(nw), .I_RESTORE_START(rs), .I_RESTORE_COUNT(cnt),
    .I_RESTORE_ADDR_WIDTH(aw), .I_SP_INIT(spi), .I_FETCH_VALID(fv), .I_FETCH_ADDR(fa),
    .I_FETCH_PC_MODIFY(pm), .I_DEBUG_MODE(dbg), .I_DATA_ACCESS(da), .I_DATA_ADDR(dadr),
    .I_VACANT_ACCESS_IRQ_ENABLE(en), .I_VACANT_ACCESS_FLAG_CLEAR(clr), .O_PC(o_pc),
    .O_PC_VALID(o_pc_valid), .O_STACK_READ(o_rd), .O_STACK_READ_ADDR(o_rd_addr),
    .O_STACK_READ_EXTRA(o_rd_extra), .O_SP(o_sp), .O_RESTORE_BUSY(o_busy),
    .O_VACANT_ACCESS_FLAG(o_flag), .O_VACANT_IRQ(o_irq));
  fsq_mem_model i_fsq_mem_model (.i_clk(clk), .i_rst_n(rst_n), .i_count_clear(cc),
    .i_stack_read(o_rd), .i_stack_read_addr(o_rd_addr), .o_read_count(rd_count), .o_over_count(over_count));

  // Free-running system clock, 20 ns period
  always #10 clk = ~clk;

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard: the whole run needs far fewer cycles than this
  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  // Watcher: settled outputs are compared with the oldest note at the falling edge
  always @(negedge clk) begin
    if (o_pc_valid === 1'b1) check(exp_pc.size() > 0 && o_pc === exp_pc.pop_front(), "jump pc");
    if (o_rd === 1'b1) check(exp_rd.size() > 0 && {o_rd_addr, o_rd_extra} === exp_rd.pop_front(), "read");
  end

  task automatic flag_is(input logic f, input string msg);
    check(o_flag === f && o_irq === (f & en), msg);
  endtask

  // Clear pulse; the flag must hold until this point and then drop
  task automatic clear_flag();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    flag_is(1'b0, "flag not cleared");
  endtask

  task automatic jump(input logic [ADDR_W-1:0] t, input logic [WORD_W-1:0] w);
    logic q;
    q = ((w & JUMP_QUIRK_MASK) == 16'h0040) || ((w & JUMP_QUIRK_MASK) == 16'h0050);
    jt = 1'b1;
    tgt = t;
    nw = w;
    exp_pc.push_back(q ? t + JUMP_EXTRA_INC : t);
    @(negedge clk);
  endtask

  task automatic restore(input int n, input logic w, input logic [ADDR_W-1:0] init, input logic ef);
    logic [ADDR_W-1:0] step;
    int k;
    step = w ? STEP_ADDR_WIDTH : STEP_WORD_WIDTH;
    for (int i = 0; i <= n; i++) exp_rd.push_back({init + ADDR_W'(i) * step, i == n});
    {rs, cc, aw, spi, cnt} = {2'b11, w, init, CNT_W'(n)};
    @(negedge clk);
    {rs, cc} = 2'b00;
    k = 0;
    while (o_busy === 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    repeat (2) @(negedge clk);
    check(exp_rd.size() == 0 && rd_count === 8'(n + 1), "read count");
    check(o_sp === init + ADDR_W'(n) * step, "stack pointer");
    check(over_count === 8'(ef), "read past stack top");
    flag_is(ef, "restore flag");
    if (ef) clear_flag();
  endtask

  task automatic access(input logic f, input logic [ADDR_W-1:0] a, input logic m, input logic d, input logic ef);
    {fv, da, fa, dadr, pm, dbg} = {f, ~f, a, a, m, d};
    @(negedge clk);
    {fv, da} = 2'b00;
    @(negedge clk);
    flag_is(ef, "access flag");
    if (ef) clear_flag();
  endtask

  initial begin
    {clk, rst_n, jt, rs, aw, fv, pm, dbg, da, en, clr, cc} = 12'h001;
    {tgt, spi, fa, dadr, nw, cnt} = '0;
    void'($urandom(32'hBD1A0720));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Back-to-back jumps over quirk and harmless following words
    for (int i = 0; i < 16; i++) jump(SEC_BASE[1] + ADDR_W'($urandom % 32'h8000) * 20'h00002,
      (i < 8) ? words[i] : 16'($urandom));
    // Spacer word after the jump keeps the landing address exact
    jump(SEC_BASE[1] + 20'h00100, 16'h0000);
    jt = 1'b0;
    repeat (3) @(negedge clk);
    check(exp_pc.size() == 0, "jump results missing");
    $display("test jump done");
    // Restore reaching the stack top, then one step below it, both widths
    for (int w = 0; w < 2; w++) begin
      int n;
      logic [ADDR_W-1:0] st;
      n = 2 + ($urandom % 14);
      st = w ? STEP_ADDR_WIDTH : STEP_WORD_WIDTH;
      restore(n, w[0], STACK_TOP - ADDR_W'(n) * st, 1'b1);
      restore(n, w[0], STACK_TOP - ADDR_W'(n + 1) * st, 1'b0);
      restore(n - 1, w[0], STACK_TOP - ADDR_W'(n) * st, 1'b0);
      restore(15, w[0], STACK_TOP - 20'd15 * st, 1'b1);
    end
    {rs, cnt} = {1'b1, 4'h0};
    @(negedge clk);
    rs = 1'b0;
    check(o_busy === 1'b0, "zero count taken");
    $display("test restore done");
    // Flag with interrupt masked, then enabled; an event wins over a clear
    en = 1'b0;
    {da, dadr} = {1'b1, 20'h03000};
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    flag_is(1'b1, "set versus clear");
    {da, clr} = 2'b00;
    en = 1'b1;
    repeat (3) @(negedge clk);
    flag_is(1'b1, "irq while enabled");
    clear_flag();
    $display("test irq done");
    // Fetch tails: isolated section, free run and debug, plus contiguous section
    access(1'b1, 20'h13FFC, 1'b1, 1'b0, 1'b1);
    access(1'b1, 20'h13FFB, 1'b1, 1'b0, 1'b0);
    access(1'b1, 20'h13FF8, 1'b1, 1'b1, 1'b1);
    access(1'b1, 20'h13FF7, 1'b1, 1'b1, 1'b0);
    access(1'b1, 20'h13FFE, 1'b0, 1'b1, 1'b0);
    access(1'b1, 20'h0FFFE, 1'b1, 1'b1, 1'b0);
    access(1'b0, 20'h04400, 1'b0, 1'b0, 1'b0);
    $display("test fetch done");
    complete_run();
  end
endmodule
